/* File: rtl/reader_director_decoder.sv */
// Director function decoder with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
`include "reader_director_params.svh"
module reader_director_decoder
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_reader_ready,
  input wire logic i_mirror_done,
  input wire logic i_page_done,
  input wire logic i_doc_ready,
  input wire logic i_mark_done,
  input wire logic i_out_of_zone,
  input wire logic i_belt_inch,
  input wire logic i_mirror_outside,
  input wire logic [7:0] i_terminal_mirror_coordinate,
  input wire logic i_char_valid,
  input wire logic [7:0] i_char,
  input wire logic [7:0] i_servo_count,
  input wire logic [6:0] i_peak_voltage,
  input wire logic i_beyond_optics,
  output logic [15:0] o_data_word,
  output logic o_data_valid,
  output logic o_mirror_start,
  output logic o_mirror_zero,
  output logic [7:0] o_mirror_target,
  output logic o_page_start,
  output logic [3:0] o_page_count,
  output logic [9:0] o_step_mils,
  output logic o_sort_start,
  output logic o_sort_pocket2,
  output logic o_mark_start,
  output logic o_scan_two_high,
  output logic o_font_clear,
  output logic o_ctrl_clear,
  output logic o_table_wr,
  output logic o_table_font,
  output logic [5:0] o_table_index,
  output logic [15:0] o_table_data,
  output logic o_busy,
  output logic o_irq
);
  import reader_director_pkg::*;

  // Basic line size for the given pitch controls
  function automatic logic [9:0] step_mils(input logic mini, input logic [1:0] pitch);
    logic [9:0] s;
    s = `STEP_168_MILS;
    case (pitch)
      2'b01: s = `STEP_192_MILS;
      2'b10: s = `STEP_200_MILS;
      2'b11: s = `STEP_248_MILS;
      default: s = `STEP_168_MILS;
    endcase
    step_mils = mini ? `STEP_MINI_MILS : s;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r, pin_d_r;
  logic [7:0] pin_raw, pin_rise;
  assign pin_raw = {i_mirror_outside, i_belt_inch, i_out_of_zone, i_mark_done, i_doc_ready, i_page_done,
    i_mirror_done, i_reader_ready};
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_s3_r <= 8'h00;
      pin_r <= 8'h00;
      pin_d_r <= 8'h00;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= (~(pin_s2_r ^ pin_s3_r) & pin_s3_r) | ((pin_s2_r ^ pin_s3_r) & pin_r);
      pin_d_r <= pin_r;
    end
  end
  assign pin_rise = pin_r & ~pin_d_r;
  logic ready_s, mirror_ev, page_ev, doc_ev, mark_ev, zone_ev, belt_ev, outside_s;
  assign ready_s = pin_r[0];
  assign mirror_ev = pin_rise[1];
  assign page_ev = pin_rise[2];
  assign doc_ev = pin_rise[3];
  assign mark_ev = pin_rise[4];
  assign zone_ev = pin_rise[5];
  assign belt_ev = pin_rise[6];
  assign outside_s = pin_r[7];

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, write acts at the edge that sees waitrequest low
  logic wait_r;
  logic wr_go, rd_go, dir_wr, data_wr, ctrl_wr;
  logic [15:0] word;
  logic [3:0] dir_code;
  state_t state_r;
  logic can_accept, param_go, pos_go, mech_go;
  logic clr_ctrl, clr_int;
  assign wr_go = i_avs_write && !wait_r;
  assign rd_go = i_avs_read && !wait_r;
  assign word = i_avs_writedata[15:0];
  assign dir_code = i_avs_writedata[`DIR_CODE_HI:`DIR_CODE_LO];
  assign dir_wr = wr_go && (i_avs_address == `OFS_DIRECTOR);
  assign data_wr = wr_go && (i_avs_address == `OFS_PARAM_DATA);
  assign ctrl_wr = wr_go && (i_avs_address == `OFS_CONTROL);
  // Words are taken only while ready and idle; others are refused
  assign can_accept = ready_s && (state_r == ST_IDLE);
  logic hang_r;
  assign param_go = dir_wr && (dir_code == `DIR_PARAM) && can_accept;
  assign pos_go = dir_wr && (dir_code == `DIR_POSITION) && can_accept && !hang_r;
  assign mech_go = dir_wr && (dir_code == `DIR_MECH) && can_accept;
  assign clr_ctrl = ctrl_wr && i_avs_writedata[`BIT_CLR_CTRL];
  assign clr_int = clr_ctrl || (ctrl_wr && i_avs_writedata[`BIT_CLR_INT]) ||
    ((param_go || mech_go) && word[`BIT_CLR_INT]);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      wait_r <= 1'b1;
    else if ((i_avs_read || i_avs_write) && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end
  assign o_avs_waitrequest = wait_r;

  //////////////////////////////////////////////////////////////////////////////
  // Parameter word fields, held for the read path
  char_mode_t char_mode_r;
  table_cmd_t table_cmd_r;
  logic [5:0] word_count_r;
  logic eop_req_r, alarm_req_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      char_mode_r <= CM_ASSEMBLED;
      table_cmd_r <= TC_CLR_FONT;
      word_count_r <= 6'h00;
      o_scan_two_high <= 1'b0;
    end
    else if (param_go)
    begin
      char_mode_r <= char_mode_t'(word[`CHAR_MODE_HI:`CHAR_MODE_LO]);
      o_scan_two_high <= word[`BIT_SCAN_TWO];
      table_cmd_r <= table_cmd_t'(word[`TABLE_CMD_HI:`TABLE_CMD_LO]);
      word_count_r <= word[`WORD_COUNT_HI:`WORD_COUNT_LO];
    end
  end

  // Interrupt requests ride on each accepted parameter or mechanical word and die with a clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      eop_req_r <= 1'b0;
      alarm_req_r <= 1'b0;
    end
    else if (param_go || mech_go)
    begin
      eop_req_r <= word[`BIT_EOP_REQ];
      alarm_req_r <= word[`BIT_ALARM_REQ];
    end
    else if (clr_int)
    begin
      eop_req_r <= 1'b0;
      alarm_req_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state and pending actions
  logic mirror_pend_r, page_pend_r, sort_pend_r, mark_pend_r, mark_run_r, zero_op_r;
  logic [5:0] words_left_r, table_idx_r, belt_cnt_r;
  logic runout;
  logic all_done;
  logic eop_set, alarm_set;
  assign runout = sort_pend_r && belt_ev && (belt_cnt_r == `RUNOUT_INCHES - 6'h01);
  assign all_done = !mirror_pend_r && !page_pend_r && !sort_pend_r && !mark_pend_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_r <= ST_IDLE;
      words_left_r <= 6'h00;
    end
    else if (clr_ctrl)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (param_go && (word[`TABLE_CMD_HI:`TABLE_CMD_LO] != TC_CLR_FONT) &&
              (word[`WORD_COUNT_HI:`WORD_COUNT_LO] != 6'h00))
          begin
            state_r <= ST_PARAM;
            words_left_r <= word[`WORD_COUNT_HI:`WORD_COUNT_LO];
          end
          else if (pos_go && ((word[`TMC_HI:`TMC_LO] != 8'h00) || (word[`ADVANCE_HI:`ADVANCE_LO] != 4'h0)))
            state_r <= ST_MOTION;
          else if (mech_go)
            state_r <= ST_MECH;
        end
        ST_PARAM:
        begin
          if (data_wr)
          begin
            words_left_r <= words_left_r - 6'h01;
            if (words_left_r == 6'h01)
              state_r <= ST_IDLE;
          end
        end
        ST_MOTION, ST_MECH:
        begin
          if (all_done)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Table load strobes; host keeps counts within 48 font or 8 control words
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_font_clear <= 1'b0;
      o_ctrl_clear <= 1'b0;
      o_table_wr <= 1'b0;
      o_table_font <= 1'b0;
      o_table_index <= 6'h00;
      o_table_data <= 16'h0000;
      table_idx_r <= 6'h00;
    end
    else
    begin
      o_font_clear <= param_go && (word[`TABLE_CMD_HI:`TABLE_CMD_LO] == TC_CLR_FONT);
      o_ctrl_clear <= param_go && (word[`TABLE_CMD_HI:`TABLE_CMD_LO] == TC_ENTER_CTRL);
      o_table_wr <= (state_r == ST_PARAM) && data_wr && !clr_ctrl;
      if (param_go)
      begin
        table_idx_r <= 6'h00;
        o_table_font <= (word[`TABLE_CMD_HI:`TABLE_CMD_LO] == TC_ENTER_FONT);
      end
      else if ((state_r == ST_PARAM) && data_wr)
      begin
        // Replace writes land on matching indices of the held table
        o_table_index <= table_idx_r;
        o_table_data <= i_avs_writedata[15:0];
        table_idx_r <= table_idx_r + 6'h01;
      end
    end
  end

  // Motion launches and completion tracking
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mirror_pend_r <= 1'b0;
      page_pend_r <= 1'b0;
      sort_pend_r <= 1'b0;
      mark_pend_r <= 1'b0;
      mark_run_r <= 1'b0;
      zero_op_r <= 1'b0;
      belt_cnt_r <= 6'h00;
      o_mirror_start <= 1'b0;
      o_mirror_zero <= 1'b0;
      o_mirror_target <= 8'h00;
      o_page_start <= 1'b0;
      o_page_count <= 4'h0;
      o_step_mils <= `STEP_168_MILS;
      o_sort_start <= 1'b0;
      o_sort_pocket2 <= 1'b0;
      o_mark_start <= 1'b0;
    end
    else if (clr_ctrl)
    begin
      mirror_pend_r <= 1'b0;
      page_pend_r <= 1'b0;
      sort_pend_r <= 1'b0;
      mark_pend_r <= 1'b0;
      mark_run_r <= 1'b0;
      o_mirror_start <= 1'b0;
      o_page_start <= 1'b0;
      o_sort_start <= 1'b0;
      o_mark_start <= 1'b0;
    end
    else
    begin
      o_mirror_start <= 1'b0;
      o_page_start <= 1'b0;
      o_sort_start <= 1'b0;
      o_mark_start <= 1'b0;
      if (pos_go)
      begin
        // Both motions start together; a zero field starts nothing
        o_mirror_target <= word[`TMC_HI:`TMC_LO];
        o_mirror_zero <= 1'b0;
        o_mirror_start <= (word[`TMC_HI:`TMC_LO] != 8'h00);
        mirror_pend_r <= (word[`TMC_HI:`TMC_LO] != 8'h00);
        zero_op_r <= 1'b0;
        o_page_count <= word[`ADVANCE_HI:`ADVANCE_LO];
        o_page_start <= (word[`ADVANCE_HI:`ADVANCE_LO] != 4'h0);
        page_pend_r <= (word[`ADVANCE_HI:`ADVANCE_LO] != 4'h0);
        o_step_mils <= step_mils(word[`BIT_MINI_STEP], word[`PITCH_HI:`PITCH_LO]);
      end
      else if (mech_go)
      begin
        zero_op_r <= word[`BIT_ZERO_MIRROR];
        o_mirror_zero <= word[`BIT_ZERO_MIRROR];
        // Zero mirror already outside the scan area is a no-op
        if (word[`BIT_ZERO_MIRROR])
        begin
          o_mirror_start <= !outside_s;
          mirror_pend_r <= !outside_s;
        end
        else
        begin
          o_mirror_target <= i_terminal_mirror_coordinate;
          o_mirror_start <= 1'b1;
          mirror_pend_r <= 1'b1;
        end
        if ((word[`ACTION_HI:`ACTION_LO] == `ACTION_POCKET1) || (word[`ACTION_HI:`ACTION_LO] == `ACTION_POCKET2))
        begin
          o_sort_start <= 1'b1;
          o_sort_pocket2 <= (word[`ACTION_HI:`ACTION_LO] == `ACTION_POCKET2);
          sort_pend_r <= 1'b1;
          belt_cnt_r <= 6'h00;
        end
        mark_pend_r <= (word[`ACTION_HI:`ACTION_LO] == `ACTION_MARK);
        mark_run_r <= 1'b0;
      end
      else
      begin
        if (mirror_ev)
          mirror_pend_r <= 1'b0;
        // Leaving the read zone ends the advance early
        if (page_ev || zone_ev)
          page_pend_r <= 1'b0;
        if (sort_pend_r && belt_ev)
          belt_cnt_r <= belt_cnt_r + 6'h01;
        if (sort_pend_r && (doc_ev || runout))
          sort_pend_r <= 1'b0;
        // Pen waits for the mirror: they never move together
        if (mark_pend_r && !mark_run_r && !mirror_pend_r)
        begin
          o_mark_start <= 1'b1;
          mark_run_r <= 1'b1;
        end
        if (mark_run_r && mark_ev)
        begin
          mark_pend_r <= 1'b0;
          mark_run_r <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags and interrupt response; a set beats a same-cycle clear
  logic eop_r, alarm_r, no_sort_r, scan_gate_r, refused_r;
  logic [7:0] mirror_pos_r;
  assign eop_set = ((state_r != ST_IDLE) && (state_r != ST_PARAM) && all_done && !clr_ctrl) ||
    ((state_r == ST_PARAM) && data_wr && (words_left_r == 6'h01) && !clr_ctrl);
  assign alarm_set = (page_pend_r && zone_ev) || runout || (pin_d_r[0] && !ready_s);
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      eop_r <= 1'b0;
      alarm_r <= 1'b0;
      no_sort_r <= 1'b0;
      hang_r <= 1'b0;
      refused_r <= 1'b0;
      scan_gate_r <= 1'b0;
      mirror_pos_r <= 8'h00;
      o_irq <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      eop_r <= eop_set || (eop_r && !clr_int);
      alarm_r <= alarm_set || (alarm_r && !clr_int);
      o_irq <= (eop_set && eop_req_r) || (alarm_set && alarm_req_r) || (o_irq && !clr_int);
      refused_r <= (dir_wr && !param_go && !pos_go && !mech_go) || (refused_r && !clr_int);
      o_busy <= (state_r != ST_IDLE) || param_go || pos_go || mech_go;
      // Page pushed out of the zone blocks advances until a sort
      if (page_pend_r && zone_ev)
      begin
        no_sort_r <= 1'b1;
        hang_r <= 1'b1;
      end
      else if (mech_go && ((word[`ACTION_HI:`ACTION_LO] == `ACTION_POCKET1) ||
               (word[`ACTION_HI:`ACTION_LO] == `ACTION_POCKET2)))
      begin
        no_sort_r <= 1'b0;
        hang_r <= 1'b0;
      end
      if (mirror_pend_r && mirror_ev && !zero_op_r)
      begin
        scan_gate_r <= 1'b1;
        mirror_pos_r <= o_mirror_target;
      end
      else if ((state_r == ST_MECH) && all_done && zero_op_r)
      begin
        scan_gate_r <= 1'b0;
        mirror_pos_r <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-back data latched as waitrequest falls
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_avs_readdata <= 32'h00000000;
    else if (i_avs_read && wait_r)
    begin
      case (i_avs_address)
        `OFS_STATUS: o_avs_readdata <= {8'h00, mirror_pos_r, 7'h00, refused_r, scan_gate_r, no_sort_r, alarm_r,
          eop_r, 1'b0, o_irq, o_busy, ready_s};
        `OFS_MODE: o_avs_readdata <= {12'h000, alarm_req_r, eop_req_r, state_r, word_count_r, table_cmd_r,
          o_scan_two_high, char_mode_r, 5'h00};
        `OFS_PARAM_DATA: o_avs_readdata <= {26'h0000000, words_left_r};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read character formatting by character mode
  logic [7:0] first_char_r;
  logic half_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_data_word <= 16'h0000;
      o_data_valid <= 1'b0;
      first_char_r <= 8'h00;
      half_r <= 1'b0;
    end
    else
    begin
      o_data_valid <= 1'b0;
      if (param_go || clr_ctrl)
        half_r <= 1'b0;
      else if (i_char_valid)
      begin
        case (char_mode_r)
          CM_ASSEMBLED:
          begin
            // First character goes high; odd last one waits
            if (!half_r)
              first_char_r <= i_char;
            else
            begin
              o_data_word <= {first_char_r, i_char};
              o_data_valid <= 1'b1;
            end
            half_r <= !half_r;
          end
          CM_SERVO:
          begin
            o_data_word <= {i_servo_count, i_char};
            o_data_valid <= 1'b1;
          end
          CM_CHAR:
          begin
            o_data_word <= {8'h00, i_char};
            o_data_valid <= 1'b1;
          end
          CM_PEAK:
          begin
            o_data_word <= {i_beyond_optics, i_peak_voltage, i_char};
            o_data_valid <= 1'b1;
          end
          default: o_data_valid <= 1'b0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_busy_dir;
    dir_wr && (state_r != ST_IDLE);
  endsequence
  sequence s_param_load;
    param_go && (word[`TABLE_CMD_HI:`TABLE_CMD_LO] != TC_CLR_FONT) && (word[`WORD_COUNT_HI:`WORD_COUNT_LO] != 6'h00);
  endsequence
  a_busy_refuse: assert property (s_busy_dir |=> !o_mirror_start && !o_page_start && !o_font_clear)
    else $error("word taken while busy");
  a_param_busy: assert property (s_param_load |=> (state_r == ST_PARAM) ##1 o_busy)
    else $error("parameter load did not go busy");
  a_zero_noop: assert property (pos_go && (word[`ADVANCE_HI:`ADVANCE_LO] == 4'h0) |=> !o_page_start)
    else $error("page moved on zero count");
  a_mini_step: assert property (pos_go && word[`BIT_MINI_STEP] |=> o_step_mils == `STEP_MINI_MILS)
    else $error("mini step size wrong");
  a_hang_block: assert property (hang_r && dir_wr |=> !o_page_start)
    else $error("page advance while hung");
  a_zone_alarm: assert property (page_pend_r && zone_ev && !clr_ctrl |=> alarm_r && no_sort_r)
    else $error("out of zone without alarm");
  a_pen_mirror: assert property (o_mark_start |-> !mirror_pend_r)
    else $error("pen started with mirror moving");
  a_eop_both: assert property ((state_r == ST_MECH) && !all_done |=> !$rose(eop_r))
    else $error("end of operation before all actions");
  a_irq_gate: assert property ($rose(o_irq) |-> $past(eop_req_r) || $past(alarm_req_r))
    else $error("interrupt without request");
  a_servo_fmt: assert property (i_char_valid && (char_mode_r == CM_SERVO) && !param_go && !clr_ctrl
    |=> o_data_valid && (o_data_word == {$past(i_servo_count), $past(i_char)}))
    else $error("servo mode word wrong");
endmodule
`default_nettype wire

/* File: rtl/reader_director_params.svh */
// Offsets, field positions, codes and step sizes for the director decoder
`ifndef READER_DIRECTOR_PARAMS_SVH
`define READER_DIRECTOR_PARAMS_SVH
// Register byte offsets
`define OFS_DIRECTOR 5'h00
`define OFS_STATUS 5'h04
`define OFS_MODE 5'h08
`define OFS_PARAM_DATA 5'h0c
`define OFS_CONTROL 5'h10
// Director code field of a director write
`define DIR_CODE_HI 19
`define DIR_CODE_LO 16
`define DIR_PARAM 4'h2
`define DIR_POSITION 4'h3
`define DIR_MECH 4'h4
// Common function word bits
`define BIT_CLR_CTRL 0
`define BIT_CLR_INT 1
`define BIT_EOP_REQ 3
`define BIT_ALARM_REQ 4
// Parameter word fields
`define CHAR_MODE_HI 6
`define CHAR_MODE_LO 5
`define BIT_SCAN_TWO 7
`define TABLE_CMD_HI 9
`define TABLE_CMD_LO 8
`define WORD_COUNT_HI 15
`define WORD_COUNT_LO 10
// Position word fields
`define TMC_HI 7
`define TMC_LO 0
`define ADVANCE_HI 11
`define ADVANCE_LO 8
`define BIT_MINI_STEP 13
`define PITCH_HI 15
`define PITCH_LO 14
// Mechanical action word fields
`define BIT_ZERO_MIRROR 12
`define ACTION_HI 15
`define ACTION_LO 13
`define ACTION_POCKET1 3'h1
`define ACTION_POCKET2 3'h3
`define ACTION_MARK 3'h4
// Page step sizes in thousandths of an inch
`define STEP_MINI_MILS 10'h028
`define STEP_168_MILS 10'h0a8
`define STEP_192_MILS 10'h0c0
`define STEP_200_MILS 10'h0c8
`define STEP_248_MILS 10'h0f8
// Belt travel that marks document run-out, in inches
`define RUNOUT_INCHES 6'h1e
`endif

/* File: rtl/reader_director_pkg.sv */
// Types shared by the director decoder
`default_nettype none
package reader_director_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PARAM = 2'b01, ST_MOTION = 2'b11, ST_MECH = 2'b10} state_t;
  typedef enum logic [1:0] {CM_ASSEMBLED = 2'b00, CM_SERVO = 2'b01, CM_CHAR = 2'b10, CM_PEAK = 2'b11} char_mode_t;
  typedef enum logic [1:0] {TC_CLR_FONT = 2'b00, TC_ENTER_CTRL = 2'b01, TC_ENTER_FONT = 2'b10,
    TC_REPLACE_CTRL = 2'b11} table_cmd_t;
endpackage
`default_nettype wire

/* File: verif/reader_mech_model.sv */
// Behavioural reader mechanics answering the decoder's start pulses
`timescale 1ns/100ps
`default_nettype none
module reader_mech_model
#(
  parameter int DLY = 6
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_mirror_start,
  input wire logic i_page_start,
  input wire logic i_sort_start,
  input wire logic i_mark_start,
  output logic o_ready,
  output logic [3:0] o_done
);
  logic [3:0] start;
  int cnt [4];
  assign start = {i_mark_start, i_sort_start, i_page_start, i_mirror_start};
  assign o_ready = i_rst_b;
  // Done held six cycles so the decoder's input filter sees it
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    for (int k = 0; k < 4; k++)
      if (!i_rst_b)
        cnt[k] <= 0;
      else if (start[k])
        cnt[k] <= 1;
      else if (cnt[k] != 0 && cnt[k] < DLY + 6)
        cnt[k] <= cnt[k] + 1;
      else
        cnt[k] <= 0;
  // Done window after the motion delay
  always_comb
    for (int k = 0; k < 4; k++)
      o_done[k] = cnt[k] > DLY;
endmodule
`default_nettype wire

/* File: verif/tb_reader_director_decoder.sv */
// Bus-driven bench for the director decoder
`timescale 1ns/100ps
`default_nettype none
module tb_reader_director_decoder;
  logic clk = 0, rst_b = 0, rd = 0, wr = 0, cv = 0, oz = 0, mo = 0, rdy, ms, ss, ks, dv, pst, irq, wq, cc, tw;
  logic tf, sp2, mz, scan, fc, bsy;
  logic [3:0] pc;
  logic [5:0] ti;
  logic [22:0] tbl;
  logic [13:0] stp;
  logic [4:0] a = 5'h00;
  logic [31:0] wd = 32'h0, rq, q;
  logic [3:0] dn;
  logic [7:0] tgt, mt, ch = 8'h41, terminal_mirror_coordinate = 8'h9c;
  logic [9:0] sm;
  logic [15:0] dw, dwo, td;
  int err_total = 0, n_checks = 0, n_mir = 0, n_mark = 0, n_tbl = 0, n_clr = 0, n_fc = 0;
  logic [15:0] pw [5] = '{16'h0340, 16'h4340, 16'h8340, 16'hc340, 16'h2340};
  logic [9:0] ps_exp [5] = '{10'h0a8, 10'h0c0, 10'h0c8, 10'h0f8, 10'h028};
  always #10 clk = ~clk;
  reader_director_decoder dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_avs_address(a), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rq), .o_avs_waitrequest(wq),
    .i_reader_ready(rdy), .i_mirror_done(dn[0]), .i_page_done(dn[1]), .i_doc_ready(dn[2]),
    .i_mark_done(dn[3]), .i_out_of_zone(oz), .i_belt_inch(1'b0), .i_mirror_outside(mo),
    .i_terminal_mirror_coordinate(terminal_mirror_coordinate), .i_char_valid(cv), .i_char(ch), .i_servo_count(8'h5a),
    .i_peak_voltage(7'h33), .i_beyond_optics(1'b1), .o_data_word(dwo), .o_data_valid(dv),
    .o_mirror_start(ms), .o_mirror_zero(mz), .o_mirror_target(mt), .o_page_start(pst), .o_page_count(pc),
    .o_step_mils(sm), .o_sort_start(ss), .o_sort_pocket2(sp2), .o_mark_start(ks), .o_scan_two_high(scan),
    .o_font_clear(fc), .o_ctrl_clear(cc), .o_table_wr(tw), .o_table_font(tf), .o_table_index(ti),
    .o_table_data(td), .o_busy(bsy), .o_irq(irq));
  reader_mech_model mech (.i_clk_sys(clk), .i_rst_b(rst_b), .i_mirror_start(ms), .i_page_start(pst),
    .i_sort_start(ss), .i_mark_start(ks), .o_ready(rdy), .o_done(dn));
  // Capture pulsed outputs so checks need not hit the exact cycle
  always @(posedge clk)
  begin
    if (dv) dw <= dwo;
    if (pst) stp <= {pc, sm};
    if (ms) tgt <= mt;
    if (tw) tbl <= {tf, ti, td};
    n_fc <= n_fc + fc;
    n_mir <= n_mir + ms;
    n_mark <= n_mark + ks;
    n_tbl <= n_tbl + tw;
    n_clr <= n_clr + cc;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq !== 1'b0 && ++n < 50);
    q = rq;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      finish_test();
    end
  endtask
  // One character strobe, then time for the formatted word to be captured
  task automatic chr(input logic [7:0] c);
    ch <= c;
    cv <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Poll status until not busy, bounded
  task automatic idle();
    for (int i = 0; i < 60; i++)
    begin
      bus(0, 5'h04, 0);
      if (q[1] === 1'b0) return;
    end
    err_total++;
    finish_test();
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    bus(0, 5'h04, 0);
    chk("ready idle", q[1:0], 2'b01);
    bus(1, 5'h00, 32'h0002_0928);
    bus(0, 5'h04, 0);
    chk("param busy", {q[1], bsy}, 2'b11);
    chk("ctrl clear", n_clr, 1);
    bus(0, 5'h08, 0);
    chk("mode", q, 32'h0005_0920);
    bus(1, 5'h0c, 32'h1111);
    bus(1, 5'h0c, 32'h2222);
    idle();
    chk("table writes", n_tbl, 2);
    chk("control word", tbl, {1'b0, 6'h01, 16'h2222});
    chk("eop", q[4], 1'b1);
    chk("irq", irq, 1'b1);
    bus(1, 5'h10, 32'h2);
    @(posedge clk);
    chk("irq clear", irq, 1'b0);
    chr(8'h41);
    chk("servo word", dw, 16'h5a41);
    bus(1, 5'h00, 32'h0002_0600);
    bus(1, 5'h0c, 32'h3333);
    idle();
    chk("font word", tbl, {1'b1, 6'h00, 16'h3333});
    bus(1, 5'h00, 32'h0002_00e0);
    chr(8'h41);
    chk("peak word", dw, 16'hb341);
    chk("scan two", scan, 1'b1);
    bus(1, 5'h00, 32'h0002_0000);
    chr(8'h41);
    chr(8'h42);
    chk("packed word", dw, 16'h4142);
    bus(1, 5'h00, 32'h0002_0040);
    chr(8'h43);
    chk("single word", dw, 16'h0043);
    chk("font clear", n_fc, 3);
    $display("parameter test done");
    for (int i = 0; i < 5; i++)
    begin
      bus(1, 5'h00, {16'h0003, pw[i]});
      idle();
      chk("step", stp, {4'h3, ps_exp[i]});
      chk("target", tgt, 8'h40);
    end
    bus(1, 5'h00, 32'h0003_0000);
    idle();
    chk("noop mirror", n_mir, 5);
    bus(1, 5'h00, 32'h0003_0100);
    oz <= 1'b1;
    idle();
    chk("no sort alarm", q[6:5], 2'b11);
    oz <= 1'b0;
    bus(1, 5'h00, 32'h0003_0100);
    bus(0, 5'h04, 0);
    chk("hang refused", q[8], 1'b1);
    bus(1, 5'h00, 32'h0004_6000);
    idle();
    chk("sort pocket2", {sp2, q[6]}, 2'b10);
    bus(1, 5'h00, 32'h0004_8000);
    bus(1, 5'h00, 32'h0003_0150);
    idle();
    chk("mark", n_mark, 1);
    chk("mirror with mark", n_mir, 7);
    chk("busy refused", tgt, 8'h9c);
    mo <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1, 5'h00, 32'h0004_1000);
    idle();
    chk("outside noop", n_mir, 7);
    chk("gate clear", {q[23:16], q[7]}, 9'h000);
    mo <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1, 5'h00, 32'h0004_1000);
    idle();
    chk("zero mirror", mz, 1'b1);
    chk("zero moves", n_mir, 8);
    bus(0, 5'h1c, 0);
    chk("unmapped", q, 32'h0);
    $display("position and action test done");
    finish_test();
  end
endmodule
`default_nettype wire
